// *** design/mode_strap_pkg.sv ***
package mode_strap_pkg;

   // ==========================================================
   // Strap encodings
   // ==========================================================
   localparam logic [2:0] MODE_QUAD_LBUS = 3'h0;
   localparam logic [2:0] MODE_QUAD_PPORT = 3'h1;
   localparam logic [2:0] MODE_QUAD_PINID = 3'h2;
   localparam logic [2:0] MODE_ENH_UNIQUE = 3'h3;
   localparam logic [2:0] MODE_ENH_LBUS = 3'h4;
   localparam logic [2:0] MODE_ENH_PPORT = 3'h5;
   localparam logic [2:0] MODE_TEST = 3'h6;
   localparam logic [2:0] MODE_STANDALONE = 3'h7;

   // ==========================================================
   // Field figures
   // ==========================================================
   localparam logic [7:0] FIFO_DEPTH_SHALLOW = 8'h10;
   localparam logic [7:0] FIFO_DEPTH_DEEP = 8'h80;
   localparam logic [7:0] PM_REVISION = 8'h11;
   localparam logic [1:0] EXTRA_EEPROM_ZONES = 2'h2;
   localparam logic [1:0] BASE_EEPROM_ZONES = 2'h3;
   localparam int MIO_WIDTH = 12;
   localparam int MIO_SELECT_BIT = 11;
   localparam logic [11:0] MIO_ALL_GPIO = 12'hFFF;
   localparam logic [11:0] MIO_ENH_GPIO = 12'h7FF;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   localparam logic [1:0] SETTLE_DONE = 2'h3;

   // Function layout choices
   typedef enum logic [1:0] {
      FN1_LOCAL_BUS,
      FN1_PARALLEL_PORT,
      FN1_NONE
   } fn1_kind_t;

   // Decoded configuration; all but unique_bars held from reset to reset
   typedef struct packed {
      logic enhanced;
      logic standalone;
      logic test_mode;
      logic pci_enabled;
      fn1_kind_t fn1_kind;
      logic subsys_from_pins;
      logic unique_bars;
      logic mini_pci;
      logic intb_is_clkrun;
      logic intb_unused;
      logic route_all_inta;
      logic pme_d3cold;
      logic [11:0] gpio_mask;
      logic [7:0] pm_revision;
      logic pm_data_enable;
      logic [2:0] eeprom_zones;
      logic [7:0] fifo_depth;
   } mode_cfg_t;

endpackage : mode_strap_pkg

// *** design/strap_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for strap pins
// ==========================================================
module strap_sync (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [4:0] pins_i,
   output logic [4:0] pins_o
);

   logic [4:0] meta;

   // First stage feeds only the second; free-running so straps pass during reset
   always_ff @(posedge sys_clk_i) begin
      meta <= pins_i;
      pins_o <= meta;
   end

endmodule : strap_sync

`default_nettype wire

// *** design/mode_decode.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Pure decode of strap levels into a configuration
// ==========================================================
module mode_decode (
   input wire logic [2:0] mode_i,
   input wire logic fifo_depth_select_i,
   input wire logic mini_sel_i,
   input wire logic eeprom_unique_bars_i,
   output mode_strap_pkg::mode_cfg_t cfg_o
);

   // Enhanced group decode, also used below for BAR option
   function automatic logic is_enhanced(input logic [2:0] m);
      is_enhanced = (m == mode_strap_pkg::MODE_ENH_UNIQUE) ||
                    (m == mode_strap_pkg::MODE_ENH_LBUS) ||
                    (m == mode_strap_pkg::MODE_ENH_PPORT);
   endfunction : is_enhanced

   wire logic enh = is_enhanced(mode_i);
   wire logic standalone = (mode_i == mode_strap_pkg::MODE_STANDALONE);
   wire logic test = (mode_i == mode_strap_pkg::MODE_TEST);
   wire logic pport = (mode_i == mode_strap_pkg::MODE_QUAD_PPORT) ||
                      (mode_i == mode_strap_pkg::MODE_ENH_PPORT);
   wire logic no_fn1 = (mode_i == mode_strap_pkg::MODE_QUAD_PINID) || test || standalone;
   wire logic mini = enh && mini_sel_i;

   // Field assembly
   always_comb begin
      cfg_o = '0;
      cfg_o.enhanced = enh;
      cfg_o.standalone = standalone;
      cfg_o.test_mode = test;
      cfg_o.pci_enabled = !standalone && !test;
      cfg_o.fn1_kind = no_fn1 ? mode_strap_pkg::FN1_NONE :
                       (pport ? mode_strap_pkg::FN1_PARALLEL_PORT : mode_strap_pkg::FN1_LOCAL_BUS);
      cfg_o.subsys_from_pins = (mode_i == mode_strap_pkg::MODE_QUAD_PINID);
      cfg_o.unique_bars = enh && ((mode_i == mode_strap_pkg::MODE_ENH_UNIQUE) || eeprom_unique_bars_i);
      cfg_o.mini_pci = mini;
      cfg_o.intb_is_clkrun = mini;
      cfg_o.intb_unused = enh && !mini_sel_i;
      cfg_o.route_all_inta = enh;
      cfg_o.pme_d3cold = mini;
      cfg_o.gpio_mask = enh ? mode_strap_pkg::MIO_ENH_GPIO : mode_strap_pkg::MIO_ALL_GPIO;
      cfg_o.pm_revision = enh ? mode_strap_pkg::PM_REVISION : 8'h00;
      cfg_o.pm_data_enable = enh;
      cfg_o.eeprom_zones = enh ? (3'(mode_strap_pkg::BASE_EEPROM_ZONES) + 3'(mode_strap_pkg::EXTRA_EEPROM_ZONES))
                               : 3'(mode_strap_pkg::BASE_EEPROM_ZONES);
      cfg_o.fifo_depth = fifo_depth_select_i ? mode_strap_pkg::FIFO_DEPTH_DEEP
                                             : mode_strap_pkg::FIFO_DEPTH_SHALLOW;
   end

endmodule : mode_decode

`default_nettype wire

// *** design/device_mode_strap_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none

module device_mode_strap_decoder (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [2:0] mode_i,
   input wire logic fifo_depth_select_i,
   input wire logic [11:0] multi_purpose_io_i,
   input wire logic eeprom_unique_bars_i,
   input wire logic [7:0] pm_data_i,
   input wire logic [1:0] pm_data_scale_i,
   input wire logic [3:0] fn0_irq_i,
   input wire logic fn1_irq_i,
   input wire logic clkrun_n_i,
   input wire logic pme_event_i,
   input wire logic pme_clear_i,
   output mode_strap_pkg::mode_cfg_t cfg_o,
   output logic [11:0] gpio_in_o,
   output logic inta_n_o,
   output logic inta_n_oe_o,
   output logic intb_n_o,
   output logic intb_n_oe_o,
   output logic clkrun_n_o,
   output logic clkrun_n_oe_o,
   output logic pme_n_o,
   output logic pme_n_oe_o,
   output logic [7:0] pm_data_o,
   output logic [1:0] pm_data_scale_o
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [4:0] strap_sync_q;
   logic [11:0] mio_meta;
   logic [11:0] mio_sync;

   strap_sync u_strap_sync (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .pins_i({multi_purpose_io_i[mode_strap_pkg::MIO_SELECT_BIT], fifo_depth_select_i, mode_i}),
      .pins_o(strap_sync_q)
   );

   // Multi-purpose pins, two flops before use
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mio_meta <= 12'h000;
         mio_sync <= 12'h000;
      end else begin
         mio_meta <= multi_purpose_io_i;
         mio_sync <= mio_meta;
      end
   end

   // ==========================================================
   // Strap capture
   // ==========================================================
   // Straps are captured while reset is high, after the synchroniser has
   // settled; a reset shorter than three edges samples stale synchroniser contents, as the synchroniser has no reset.
   logic [2:0] mode_q;
   logic fifo_sel_q;
   logic mini_sel_q;
   logic [2:0] next_mode_q;
   logic next_fifo_sel_q;
   logic next_mini_sel_q;
   logic [1:0] settle;

   // Capture enables only while reset is held; the synchroniser runs during reset
   assign next_mode_q = reset_i ? strap_sync_q[2:0] : mode_q;
   assign next_fifo_sel_q = reset_i ? strap_sync_q[3] : fifo_sel_q;
   assign next_mini_sel_q = reset_i ? strap_sync_q[4] : mini_sel_q;

   always_ff @(posedge sys_clk_i) begin
      mode_q <= next_mode_q;
      fifo_sel_q <= next_fifo_sel_q;
      mini_sel_q <= next_mini_sel_q;
   end

   // Settle counter only informs nothing outside; kept to gate EEPROM field
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         settle <= mode_strap_pkg::SYNC_RESET;
      end else if (settle != mode_strap_pkg::SETTLE_DONE) begin
         settle <= settle + 2'h1;
      end
   end

   // ==========================================================
   // Decode
   // ==========================================================
   mode_strap_pkg::mode_cfg_t cfg_now;
   logic eeprom_bars_q;

   // EEPROM field arrives from same-clock loader logic
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         eeprom_bars_q <= 1'b0;
      end else if (settle == mode_strap_pkg::SETTLE_DONE) begin
         eeprom_bars_q <= eeprom_unique_bars_i;
      end
   end

   mode_decode u_mode_decode (
      .mode_i(mode_q),
      .fifo_depth_select_i(fifo_sel_q),
      .mini_sel_i(mini_sel_q),
      .eeprom_unique_bars_i(eeprom_bars_q),
      .cfg_o(cfg_now)
   );

   // ==========================================================
   // Interrupt and sideband pins
   // ==========================================================
   wire logic any_fn0 = |fn0_irq_i;
   wire logic inta_req = cfg_now.route_all_inta ? (any_fn0 || fn1_irq_i) : any_fn0;
   wire logic intb_req = !cfg_now.enhanced && fn1_irq_i && cfg_now.pci_enabled;
   wire logic clkrun_drive = cfg_now.intb_is_clkrun && !clkrun_n_i;

   // PME is sticky while pme_d3cold is set, so the context survives power-down of the core; set wins, held clear otherwise
   logic pme_pending;
   wire logic next_pme_pending = pme_event_i || (pme_pending && !pme_clear_i);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pme_pending <= 1'b0;
      end else if (cfg_now.pme_d3cold) begin
         pme_pending <= next_pme_pending;
      end else begin
         pme_pending <= 1'b0;
      end
   end

   // Open-drain outputs: level low, enable when asserting
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cfg_o <= '0;
         gpio_in_o <= 12'h000;
         inta_n_o <= 1'b1;
         inta_n_oe_o <= 1'b0;
         intb_n_o <= 1'b1;
         intb_n_oe_o <= 1'b0;
         clkrun_n_o <= 1'b1;
         clkrun_n_oe_o <= 1'b0;
         pme_n_o <= 1'b1;
         pme_n_oe_o <= 1'b0;
         pm_data_o <= 8'h00;
         pm_data_scale_o <= 2'h0;
      end else begin
         cfg_o <= cfg_now;
         gpio_in_o <= mio_sync & cfg_now.gpio_mask;
         inta_n_o <= 1'b0;
         inta_n_oe_o <= inta_req && cfg_now.pci_enabled;
         intb_n_o <= 1'b0;
         intb_n_oe_o <= intb_req && !cfg_now.intb_is_clkrun;
         clkrun_n_o <= 1'b0;
         clkrun_n_oe_o <= clkrun_drive;
         pme_n_o <= 1'b0;
         pme_n_oe_o <= pme_pending;
         pm_data_o <= cfg_now.pm_data_enable ? pm_data_i : 8'h00;
         pm_data_scale_o <= cfg_now.pm_data_enable ? pm_data_scale_i : 2'h0;
      end
   end

endmodule : device_mode_strap_decoder

`default_nettype wire

// *** test/strap_decoder_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port-level checks of the strap decoder
// ==========================================================
module strap_decoder_sva (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [3:0] fn0_irq_i,
   input wire logic fn1_irq_i,
   input wire logic [7:0] pm_data_i,
   input wire logic pme_event_i,
   input wire logic pme_clear_i,
   input wire mode_strap_pkg::mode_cfg_t cfg_o,
   input wire logic [11:0] gpio_in_o,
   input wire logic inta_n_oe_o,
   input wire logic intb_n_oe_o,
   input wire logic pme_n_oe_o,
   input wire logic [7:0] pm_data_o
);
   logic [1:0] rst_q;
   // Two quiet edges after release, so $stable never sees the load
   always_ff @(posedge sys_clk_i) rst_q <= {rst_q[0], reset_i};
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i || (|rst_q));
   AST_CFG_HOLD: assert property ($stable({cfg_o.enhanced, cfg_o.mini_pci, cfg_o.fifo_depth, cfg_o.fn1_kind}))
      else $error("config moved after reset");
   AST_GPIO_MASK: assert property ((gpio_in_o & ~cfg_o.gpio_mask) == 12'h000 && cfg_o.gpio_mask[11] == !cfg_o.enhanced)
      else $error("select pin leaks into gpio");
   AST_INTA_ROUTE: assert property (cfg_o.route_all_inta |=> inta_n_oe_o == $past((|fn0_irq_i) || fn1_irq_i))
      else $error("interrupt not routed to first line");
   AST_NO_PCI: assert property (!cfg_o.pci_enabled |-> !inta_n_oe_o && !cfg_o.enhanced)
      else $error("interrupt driven without pci");
   AST_CLKRUN: assert property (cfg_o.intb_is_clkrun == (cfg_o.enhanced && cfg_o.mini_pci))
      else $error("clock-run reuse wrong");
   AST_INTB_IDLE: assert property (cfg_o.enhanced && !cfg_o.mini_pci |-> cfg_o.intb_unused && !intb_n_oe_o)
      else $error("second line used in pci mode");
   AST_PME_D3: assert property (cfg_o.pme_d3cold == cfg_o.mini_pci)
      else $error("d3cold wake mismatch");
   AST_PME_LAT: assert property (cfg_o.pme_d3cold && pme_event_i ##1 !pme_clear_i |-> ##1 pme_n_oe_o)
      else $error("wake not driven two edges after event");
   AST_PM_DATA: assert property (cfg_o.enhanced |=> pm_data_o == $past(pm_data_i))
      else $error("pm data not passed");
   AST_FIFO: assert property (cfg_o.fifo_depth inside {8'h10, 8'h80})
      else $error("fifo depth illegal");
   // Main scenarios reached
   COV_MINI: cover property (cfg_o.mini_pci);
   COV_ALONE: cover property (cfg_o.standalone);
   COV_INTA: cover property ($rose(inta_n_oe_o));
endmodule : strap_decoder_sva
`default_nettype wire

// *** test/pci_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host side: pulled-up open-drain lines as the host sees them
// ==========================================================
module pci_host_model (
   input wire logic inta_n_i,
   input wire logic inta_oe_i,
   input wire logic intb_n_i,
   input wire logic intb_oe_i,
   input wire logic clkrun_n_i,
   input wire logic clkrun_oe_i,
   input wire logic pme_n_i,
   input wire logic pme_oe_i,
   output logic inta_line_o,
   output logic intb_line_o,
   output logic pme_line_o
);
   // Released lines float to the pull-up; second line shares its pin with clock-run
   assign inta_line_o = inta_oe_i ? inta_n_i : 1'b1;
   assign intb_line_o = (intb_oe_i ? intb_n_i : 1'b1) & (clkrun_oe_i ? clkrun_n_i : 1'b1);
   assign pme_line_o = pme_oe_i ? pme_n_i : 1'b1;
endmodule : pci_host_model
`default_nettype wire

// *** test/tb_device_mode_strap_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED %0t mismatch", $time); end end
module tb_device_mode_strap_decoder;
   logic sys_clk_i, reset_i = 1, fsel = 0, eub = 0, fn1 = 0, pev = 0, pcl = 0, ckn = 1;
   logic [2:0] mode = 3'h0;
   logic [11:0] multi_purpose_io = 12'h000, gpio;
   logic [7:0] pmd = 8'h00, pmd_o;
   logic [1:0] pms = 2'h0, pms_o;
   logic [3:0] fn0 = 4'h0;
   logic a_n, a_oe, b_n, b_oe, c_n, c_oe, p_n, p_oe, a_l, b_l, p_l;
   mode_strap_pkg::mode_cfg_t cfg, exp;
   int n_fail = 0, checks_done = 0, seed = 14;
   device_mode_strap_decoder device_mode_strap_decoder_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .mode_i(mode),
      .fifo_depth_select_i(fsel), .multi_purpose_io_i(multi_purpose_io), .eeprom_unique_bars_i(eub), .pm_data_i(pmd),
      .pm_data_scale_i(pms), .fn0_irq_i(fn0), .fn1_irq_i(fn1), .clkrun_n_i(ckn), .pme_event_i(pev),
      .pme_clear_i(pcl), .cfg_o(cfg), .gpio_in_o(gpio), .inta_n_o(a_n), .inta_n_oe_o(a_oe), .intb_n_o(b_n),
      .intb_n_oe_o(b_oe), .clkrun_n_o(c_n), .clkrun_n_oe_o(c_oe), .pme_n_o(p_n), .pme_n_oe_o(p_oe),
      .pm_data_o(pmd_o), .pm_data_scale_o(pms_o));
   pci_host_model pci_host_model_i (.inta_n_i(a_n), .inta_oe_i(a_oe), .intb_n_i(b_n), .intb_oe_i(b_oe),
      .clkrun_n_i(c_n), .clkrun_oe_i(c_oe), .pme_n_i(p_n), .pme_oe_i(p_oe), .inta_line_o(a_l),
      .intb_line_o(b_l), .pme_line_o(p_l));
   initial begin
      sys_clk_i = 0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   // ==========================================================
   // Expected configuration per strap setting
   // ==========================================================
   function automatic mode_strap_pkg::mode_cfg_t expect_cfg(input logic [2:0] m, input logic f, s, e);
      mode_strap_pkg::mode_cfg_t c;
      c = '0;
      c.enhanced = m inside {3'h3, 3'h4, 3'h5};
      c.standalone = m == 3'h7;
      c.test_mode = m == 3'h6;
      c.pci_enabled = m < 3'h6;
      c.fn1_kind = (m inside {3'h0, 3'h3, 3'h4}) ? mode_strap_pkg::FN1_LOCAL_BUS
         : (m inside {3'h1, 3'h5}) ? mode_strap_pkg::FN1_PARALLEL_PORT : mode_strap_pkg::FN1_NONE;
      c.subsys_from_pins = m == 3'h2;
      c.unique_bars = m == 3'h3 || (c.enhanced && e);
      c.mini_pci = c.enhanced && s;
      c.intb_is_clkrun = c.mini_pci;
      c.intb_unused = c.enhanced && !s;
      c.route_all_inta = c.enhanced;
      c.pme_d3cold = c.mini_pci;
      c.gpio_mask = c.enhanced ? mode_strap_pkg::MIO_ENH_GPIO : mode_strap_pkg::MIO_ALL_GPIO;
      c.pm_revision = mode_strap_pkg::PM_REVISION;
      c.eeprom_zones = c.enhanced ? 3'(mode_strap_pkg::EXTRA_EEPROM_ZONES) : 3'h0;
      c.fifo_depth = f ? mode_strap_pkg::FIFO_DEPTH_DEEP : mode_strap_pkg::FIFO_DEPTH_SHALLOW;
      return c;
   endfunction : expect_cfg
   task automatic check_cfg;
      `CHK(cfg.enhanced, exp.enhanced)
      `CHK({cfg.standalone, cfg.test_mode, cfg.pci_enabled}, {exp.standalone, exp.test_mode, exp.pci_enabled})
      `CHK({cfg.fn1_kind, cfg.subsys_from_pins}, {exp.fn1_kind, exp.subsys_from_pins})
      `CHK(cfg.unique_bars, exp.unique_bars)
      `CHK({cfg.mini_pci, cfg.gpio_mask, cfg.route_all_inta}, {exp.mini_pci, exp.gpio_mask, exp.enhanced})
      `CHK({cfg.intb_is_clkrun, cfg.intb_unused, cfg.pme_d3cold}, {exp.intb_is_clkrun, exp.intb_unused, exp.pme_d3cold})
      if (exp.enhanced) `CHK({cfg.pm_revision, cfg.pm_data_enable}, {exp.pm_revision, 1'b1})
      `CHK(cfg.eeprom_zones - mode_strap_pkg::BASE_EEPROM_ZONES, exp.eeprom_zones)
      `CHK(cfg.fifo_depth, exp.fifo_depth)
   endtask : check_cfg
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   // Hang guard, far beyond the dozen reset rounds
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
   // ==========================================================
   // Every mode once, then random straps
   // ==========================================================
   initial begin
      for (int i = 0; i < 12; i++) begin
         mode = (i < 8) ? 3'(i) : 3'($random(seed));
         {fsel, eub} = 2'($random(seed));
         multi_purpose_io = 12'($random(seed));
         exp = expect_cfg(mode, fsel, multi_purpose_io[11], eub);
         reset_i = 1'b1;
         repeat (4) @(posedge sys_clk_i);
         #1 reset_i = 1'b0;
         // The loaded BAR field lands a few edges after release
         repeat (8) @(posedge sys_clk_i);
         check_cfg;
         #1 mode = ~mode;
         fsel = ~fsel;
         multi_purpose_io = ~multi_purpose_io;
         repeat (20) begin
            @(posedge sys_clk_i);
            #1 {fn0, fn1, pev, pcl, ckn} = 8'($random(seed));
            {pmd, pms, multi_purpose_io[10:0]} = 21'($random(seed));
         end
         check_cfg;
         // Quiet hold: one first-function request, wake cleared, clock-run asked
         {fn0, fn1, pev, pcl, ckn} = 8'h12;
         repeat (4) @(posedge sys_clk_i);
         #1 `CHK(gpio, multi_purpose_io & exp.gpio_mask)
         `CHK({pmd_o, pms_o}, exp.enhanced ? {pmd, pms} : 10'h000)
         `CHK({a_l, b_l, p_l}, {!exp.pci_enabled, !exp.intb_is_clkrun, 1'b1})
      end
      end_of_test;
   end
endmodule : tb_device_mode_strap_decoder
bind device_mode_strap_decoder strap_decoder_sva strap_decoder_sva_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
   .fn0_irq_i(fn0_irq_i), .fn1_irq_i(fn1_irq_i), .pm_data_i(pm_data_i), .pme_event_i(pme_event_i),
   .pme_clear_i(pme_clear_i), .cfg_o(cfg_o), .gpio_in_o(gpio_in_o), .inta_n_oe_o(inta_n_oe_o),
   .intb_n_oe_o(intb_n_oe_o), .pme_n_oe_o(pme_n_oe_o), .pm_data_o(pm_data_o));
`default_nettype wire
